// ===== logic/rfq_top.v
/*
 Receive flush / transmit inhibit pin control and dual receive queue top.
 Assumes an Avalon-MM master on the core clock and a receive/transmit
 engine that reports frame events as one-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
`include "rfq_defines.vh"

module rfq_top (
	input wire CORE_CLK_I,
	input wire SYS_RST_I,
	input wire [3:0] AVS_ADDRESS_I,
	input wire AVS_READ_I,
	input wire AVS_WRITE_I,
	input wire [31:0] AVS_WRITEDATA_I,
	input wire [3:0] AVS_BYTEENABLE_I,
	output reg [31:0] AVS_READDATA_O,
	output reg AVS_WAITREQUEST_O,
	input wire FLUSH_INHIBIT_PIN_I,
	input wire RX_FRAME_START_I,
	input wire RX_BYTE_VALID_I,
	input wire RX_THRESHOLD_CROSSED_I,
	input wire RX_FRAME_END_I,
	input wire [2:0] RX_FRAME_CLASS_I,
	input wire RX_COPY_I,
	input wire TX_BUSY_I,
	input wire [2:0] HOST_SERVICE_REQUEST_I,
	input wire HOST_READ_REQ_I,
	output reg HOST_READ_ACK_O,
	output reg QUEUE_ONE_DATA_PRESENT_O,
	output reg QUEUE_TWO_DATA_PRESENT_O,
	output reg TX_PERMIT_O,
	output reg TOKEN_RELEASE_O
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg [15:0] mode1_q; // Mode register one
	reg [15:0] mode3_q; // Mode register three
	reg [15:0] frsel_q; // Frame type select
	reg [1:0] role_q; // Pin role select bits
	reg pin_m_q, pin_q; // Pin synchroniser
	reg [15:0] rd_mux; // Read data mux
	reg in_frame_q; // Frame reception active
	reg flush_q; // Current frame marked flushed
	reg thr_q; // Threshold crossed this frame
	reg inhibit_q; // Inhibit held
	reg tx_busy_q; // Transmitter busy last cycle
	reg q2_frame_q; // Frame steered into queue two
	reg steer_valid_q; // Steering fixed for this frame
	reg clr1_q, clr2_q; // Lock clear pulses
	reg clrs1_q, clrs2_q; // Status read clear pulses
	reg host_ack_d; // Acknowledge next value
	wire to_q1, to_q2;
	wire [7:0] wptr1, wptr2;
	wire pres1, pres2, ack1, ack2;
	wire [4:0] st1, st2;
	wire flush_mode, inhibit_mode;
	wire do_flush, wr1, wr2, ok1, ok2, fl1, fl2, rd1, rd2;
	wire acc;

	assign acc = (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
	assign flush_mode = (role_q == `RFQ_ROLE_FLUSH) && pin_q;
	assign inhibit_mode = (role_q == `RFQ_ROLE_INHIBIT) && pin_q;
	// Flush only before threshold crossing
	assign do_flush = in_frame_q && (flush_q || (flush_mode && !thr_q && !RX_THRESHOLD_CROSSED_I));

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	always @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			pin_m_q <= 1'b0;
			pin_q <= 1'b0;
		end else begin
			pin_m_q <= FLUSH_INHIBIT_PIN_I;
			pin_q <= pin_m_q;
		end
	end

	// ----------------------------------------------------------------
	// Receive frame tracking
	// ----------------------------------------------------------------
	always @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			in_frame_q <= 1'b0;
			flush_q <= 1'b0;
			thr_q <= 1'b0;
			q2_frame_q <= 1'b0;
			steer_valid_q <= 1'b0;
		end else begin
			if (RX_FRAME_START_I) begin
				in_frame_q <= 1'b1;
				flush_q <= 1'b0;
				thr_q <= 1'b0;
				steer_valid_q <= 1'b1;
				q2_frame_q <= to_q2; // Class known at start
			end else if (RX_FRAME_END_I) begin
				in_frame_q <= 1'b0;
				steer_valid_q <= 1'b0;
			end else begin
				if (do_flush) begin
					flush_q <= 1'b1;
				end
				if (RX_THRESHOLD_CROSSED_I) begin
					thr_q <= 1'b1;
				end
			end
		end
	end

	// Byte writes go to the steered queue unless flushed
	assign wr1 = RX_BYTE_VALID_I && in_frame_q && !do_flush && !q2_frame_q && steer_valid_q && to_q1;
	assign wr2 = RX_BYTE_VALID_I && in_frame_q && !do_flush && q2_frame_q;
	assign ok1 = RX_FRAME_END_I && in_frame_q && !do_flush && !q2_frame_q && to_q1;
	assign ok2 = RX_FRAME_END_I && in_frame_q && !do_flush && q2_frame_q;
	assign fl1 = RX_FRAME_END_I && in_frame_q && (do_flush || (!q2_frame_q && !to_q1));
	assign fl2 = RX_FRAME_END_I && in_frame_q && do_flush && q2_frame_q;
	// Reads count only while the queue's present output shows data
	assign rd1 = HOST_READ_REQ_I && (HOST_SERVICE_REQUEST_I == `RFQ_HOST_SERVICE_REQUEST_LINES_Q1) && QUEUE_ONE_DATA_PRESENT_O;
	assign rd2 = HOST_READ_REQ_I && (HOST_SERVICE_REQUEST_I == `RFQ_HOST_SERVICE_REQUEST_LINES_Q2) && QUEUE_TWO_DATA_PRESENT_O;

	// ----------------------------------------------------------------
	// Steering and queues
	// ----------------------------------------------------------------
	rfq_steer u_steer (
		.cls_i(RX_FRAME_CLASS_I),
		.copy_i(RX_COPY_I),
		.promisc_i(mode1_q[`RFQ_MODE1_PROMISC]),
		.dual_i(mode3_q[`RFQ_MODE3_DUALQ]),
		.sel1_i(frsel_q[3:0]),
		.sel2_i(frsel_q[7:4]),
		.to_q1_o(to_q1),
		.to_q2_o(to_q2)
	);

	rfq_queue u_q1 (
		.clk_i(CORE_CLK_I),
		.rst_i(SYS_RST_I),
		.wr_i(wr1),
		.frame_start_i(RX_FRAME_START_I),
		.frame_ok_i(ok1),
		.frame_flush_i(fl1),
		.rd_i(rd1),
		.clr_lock_i(clr1_q),
		.clr_stat_i(clrs1_q),
		.wptr_o(wptr1),
		.present_o(pres1),
		.rd_ack_o(ack1),
		.wr_ok_o(),
		.stat_o(st1)
	);

	rfq_queue u_q2 (
		.clk_i(CORE_CLK_I),
		.rst_i(SYS_RST_I),
		.wr_i(wr2),
		.frame_start_i(RX_FRAME_START_I),
		.frame_ok_i(ok2),
		.frame_flush_i(fl2),
		.rd_i(rd2),
		.clr_lock_i(clr2_q),
		.clr_stat_i(clrs2_q),
		.wptr_o(wptr2),
		.present_o(pres2),
		.rd_ack_o(ack2),
		.wr_ok_o(),
		.stat_o(st2)
	);

	// ----------------------------------------------------------------
	// Transmit inhibit and host outputs
	// ----------------------------------------------------------------
	always @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			inhibit_q <= 1'b0;
			tx_busy_q <= 1'b0;
			TX_PERMIT_O <= 1'b1;
			TOKEN_RELEASE_O <= 1'b0;
			HOST_READ_ACK_O <= 1'b0;
			QUEUE_ONE_DATA_PRESENT_O <= 1'b0;
			QUEUE_TWO_DATA_PRESENT_O <= 1'b0;
		end else begin
			// Only new starts are gated; timers live elsewhere and run on
			inhibit_q <= inhibit_mode;
			tx_busy_q <= TX_BUSY_I;
			TX_PERMIT_O <= !inhibit_mode;
			TOKEN_RELEASE_O <= inhibit_mode && ((tx_busy_q && !TX_BUSY_I) || (!inhibit_q && !TX_BUSY_I));
			HOST_READ_ACK_O <= host_ack_d;
			QUEUE_ONE_DATA_PRESENT_O <= pres1;
			QUEUE_TWO_DATA_PRESENT_O <= pres2 && mode3_q[`RFQ_MODE3_DUALQ];
		end
	end

	// Acknowledge only for a queue with data
	always @* begin
		host_ack_d = ack1 || ack2;
	end

	// ----------------------------------------------------------------
	// Avalon-MM slave: one wait cycle, answer on second
	// ----------------------------------------------------------------
	always @* begin
		case (AVS_ADDRESS_I)
			`RFQ_OFS_MODE1: rd_mux = mode1_q & `RFQ_MODE1_MASK;
			`RFQ_OFS_MODE3: rd_mux = mode3_q;
			`RFQ_OFS_FRSEL: rd_mux = frsel_q;
			`RFQ_OFS_CONTROL: rd_mux = {14'h0000, role_q};
			`RFQ_OFS_STATUS2U: rd_mux = {st1, 11'h000};
			`RFQ_OFS_STATUS3U: rd_mux = {st2, 11'h000};
			`RFQ_OFS_PTR: rd_mux = {wptr2, wptr1};
			default: rd_mux = 16'h0000;
		endcase
	end

	always @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			AVS_WAITREQUEST_O <= 1'b1;
			AVS_READDATA_O <= 32'h00000000;
			mode1_q <= `RFQ_RST_16;
			mode3_q <= `RFQ_RST_16;
			frsel_q <= `RFQ_RST_16;
			role_q <= 2'h0;
			clr1_q <= 1'b0;
			clr2_q <= 1'b0;
			clrs1_q <= 1'b0;
			clrs2_q <= 1'b0;
		end else begin
			clr1_q <= 1'b0;
			clr2_q <= 1'b0;
			clrs1_q <= 1'b0;
			clrs2_q <= 1'b0;
			AVS_WAITREQUEST_O <= !(acc && AVS_WAITREQUEST_O);
			if (acc && AVS_READ_I) begin
				AVS_READDATA_O <= {16'h0000, rd_mux};
				clrs1_q <= (AVS_ADDRESS_I == `RFQ_OFS_STATUS2U);
				clrs2_q <= (AVS_ADDRESS_I == `RFQ_OFS_STATUS3U);
			end
			// Writes land at the edge that completes the transfer
			if (AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0]) begin
				case (AVS_ADDRESS_I)
					`RFQ_OFS_MODE1: mode1_q[7:0] <= AVS_WRITEDATA_I[7:0];
					`RFQ_OFS_MODE3: mode3_q[7:0] <= AVS_WRITEDATA_I[7:0];
					`RFQ_OFS_FRSEL: frsel_q[7:0] <= AVS_WRITEDATA_I[7:0];
					`RFQ_OFS_CONTROL: role_q <= AVS_WRITEDATA_I[1:0];
					`RFQ_OFS_COMMAND: begin
						// Old single-frame code falls to default
						case (AVS_WRITEDATA_I[7:0])
							`RFQ_CMD_CLR_Q1: clr1_q <= 1'b1;
							`RFQ_CMD_CLR_Q2: clr2_q <= 1'b1;
							`RFQ_CMD_CLR_ALL: begin
								clr1_q <= 1'b1;
								clr2_q <= 1'b1;
							end
							default: clr1_q <= 1'b0;
						endcase
					end
					default: clr2_q <= 1'b0;
				endcase
			end
			if (AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[1]) begin
				case (AVS_ADDRESS_I)
					`RFQ_OFS_MODE1: mode1_q[15:8] <= AVS_WRITEDATA_I[15:8];
					`RFQ_OFS_MODE3: mode3_q[15:8] <= AVS_WRITEDATA_I[15:8];
					`RFQ_OFS_FRSEL: frsel_q[15:8] <= AVS_WRITEDATA_I[15:8];
					default: clrs1_q <= 1'b0;
				endcase
			end
		end
	end

endmodule

// ===== logic/rfq_defines.vh
/*
 Register offsets, field positions, reset values and command codes for the
 receive flush/inhibit and dual receive queue controller.
 Assumes inclusion by bare name from the design modules; definitions only.
*/
//
// Behaviour
// - Flush selected and pin high discards frame
// - Flushed frame restores write pointer to saved
// - Flush only before receive threshold crossed
// - Inhibit: finish frame, release token, hold
// - Timers and state machines run during inhibit
// - Select bits: 01 flush, 10 inhibit, reset 0
// - Status bits 10 and 9 read zero
// - Old single-frame command 0x40 is ignored
// - Mode register one bit 15 reads zero
// - Bit 11 enables two queues, else queue one
// - Both selections zero means single queue
// - Queue two zero takes all but queue one's type
// - Queue one zero: nothing into queue one
// - Four-bit codes select frame classes
// - Non-SMT excludes MAC, void unless promiscuous
// - Steering only for frames passing copy criteria
// - Equal selections force single queue one
// - Subset overlap: queue one selection wins
// - Commands 20h, 21h, 3Fh clear queue locks
// - Separate data-present outputs per queue
// - No read acknowledge while data-present low
// - Queue status bits 15-11 in two registers
// - Queue locks when buffer fills, until cleared
`ifndef RFQ_DEFINES_VH
`define RFQ_DEFINES_VH

// ----------------------------------------------------------------
// Register word addresses (one per register)
// ----------------------------------------------------------------
`define RFQ_OFS_MODE1      4'h0
`define RFQ_OFS_MODE3      4'h1
`define RFQ_OFS_FRSEL      4'h2
`define RFQ_OFS_CONTROL    4'h3
`define RFQ_OFS_COMMAND    4'h4
`define RFQ_OFS_STATUS2U   4'h5
`define RFQ_OFS_STATUS3U   4'h6
`define RFQ_OFS_PTR        4'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RFQ_MODE1_PROMISC  0
`define RFQ_MODE1_SFR      15
`define RFQ_MODE3_DUALQ    11
`define RFQ_CTL_ROLE_LO    0
`define RFQ_CTL_ROLE_HI    1
`define RFQ_ST_OVR         11
`define RFQ_ST_BFL         12
`define RFQ_ST_ABT         13
`define RFQ_ST_BMT         14
`define RFQ_ST_COMP        15

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define RFQ_RST_16         16'h0000
`define RFQ_MODE1_MASK     16'h7FFF
`define RFQ_CMD_CLR_Q1     8'h20
`define RFQ_CMD_CLR_Q2     8'h21
`define RFQ_CMD_CLR_ALL    8'h3F
`define RFQ_CMD_OLD_SFR    8'h40
`define RFQ_ROLE_FLUSH     2'h1
`define RFQ_ROLE_INHIBIT   2'h2
`define RFQ_SEL_ANY        4'h0
`define RFQ_SEL_LLC        4'h1
`define RFQ_SEL_SMT        4'h2
`define RFQ_SEL_NONSMT     4'h3
`define RFQ_SEL_IMPL       4'h4
`define RFQ_SEL_MAC        4'h5
`define RFQ_SEL_SLLC       4'h6
`define RFQ_SEL_ALLC       4'h7
`define RFQ_SEL_VOID       4'h8
`define RFQ_SEL_ALLC_SMT   4'h9
`define RFQ_CLS_LLC_S      3'h0
`define RFQ_CLS_LLC_A      3'h1
`define RFQ_CLS_SMT        3'h2
`define RFQ_CLS_MAC        3'h3
`define RFQ_CLS_IMPL       3'h4
`define RFQ_CLS_VOID       3'h5
`define RFQ_QPTR_W         8
`define RFQ_HOST_SERVICE_REQUEST_LINES_Q1       3'h0
`define RFQ_HOST_SERVICE_REQUEST_LINES_Q2       3'h1

`endif

// ===== logic/rfq_steer.v
/*
 Frame class to receive queue steering.
 Assumes the class and copy flag are stable from frame start to frame end.
*/
`timescale 1ns/1ps
`include "rfq_defines.vh"

module rfq_steer (
	input wire [2:0] cls_i,
	input wire copy_i,
	input wire promisc_i,
	input wire dual_i,
	input wire [3:0] sel1_i,
	input wire [3:0] sel2_i,
	output reg to_q1_o,
	output reg to_q2_o
);

	// ----------------------------------------------------------------
	// Class match against one selection code
	// ----------------------------------------------------------------
	function match;
		input [3:0] sel;
		input [2:0] cls;
		input promisc;
		begin
			case (sel)
				`RFQ_SEL_LLC: match = (cls == `RFQ_CLS_LLC_S) || (cls == `RFQ_CLS_LLC_A);
				`RFQ_SEL_SMT: match = (cls == `RFQ_CLS_SMT);
				`RFQ_SEL_NONSMT: match = (cls != `RFQ_CLS_SMT) &&
					(promisc || ((cls != `RFQ_CLS_MAC) && (cls != `RFQ_CLS_VOID)));
				`RFQ_SEL_IMPL: match = (cls == `RFQ_CLS_IMPL);
				`RFQ_SEL_MAC: match = (cls == `RFQ_CLS_MAC);
				`RFQ_SEL_SLLC: match = (cls == `RFQ_CLS_LLC_S);
				`RFQ_SEL_ALLC: match = (cls == `RFQ_CLS_LLC_A);
				`RFQ_SEL_VOID: match = (cls == `RFQ_CLS_VOID);
				`RFQ_SEL_ALLC_SMT: match = (cls == `RFQ_CLS_LLC_A) || (cls == `RFQ_CLS_SMT);
				default: match = 1'b0; // Reserved codes match nothing
			endcase
		end
	endfunction

	reg m1; // Queue one selection matches
	reg m2; // Queue two selection matches
	reg single; // Effective single queue mode

	// Steering decision
	always @* begin
		m1 = match(sel1_i, cls_i, promisc_i);
		m2 = match(sel2_i, cls_i, promisc_i);
		single = !dual_i || (sel1_i == sel2_i);
		to_q1_o = 1'b0;
		to_q2_o = 1'b0;
		if (!copy_i) begin
			to_q1_o = 1'b0;
		end else if (single) begin
			to_q1_o = 1'b1;
		end else if (sel1_i == `RFQ_SEL_ANY) begin
			to_q2_o = m2;
		end else if (sel2_i == `RFQ_SEL_ANY) begin
			to_q1_o = m1;
			to_q2_o = !m1;
		end else if (m1) begin
			to_q1_o = 1'b1;
		end else begin
			to_q2_o = m2;
		end
	end

endmodule

// ===== logic/rfq_queue.v
/*
 One receive queue's pointers, lock and status flags.
 Assumes one write and one read request per cycle at most.
*/
`timescale 1ns/1ps
`include "rfq_defines.vh"

module rfq_queue (
	input wire clk_i,
	input wire rst_i,
	input wire wr_i,
	input wire frame_start_i,
	input wire frame_ok_i,
	input wire frame_flush_i,
	input wire rd_i,
	input wire clr_lock_i,
	input wire clr_stat_i,
	output reg [7:0] wptr_o,
	output wire present_o,
	output wire rd_ack_o,
	output wire wr_ok_o,
	output wire [4:0] stat_o
);

	reg [7:0] swptr_q; // Saved start-of-frame pointer
	reg [7:0] rptr_q; // Read pointer
	reg [7:0] cptr_q; // End of last complete frame
	reg lock_q; // Locked against input
	reg comp_q, bmt_q, abt_q, ovr_q; // Sticky flags

	assign present_o = (rptr_q != cptr_q);
	assign rd_ack_o = rd_i && present_o;
	assign wr_ok_o = !lock_q;
	assign stat_o = {comp_q, bmt_q, abt_q, lock_q, ovr_q};

	// ----------------------------------------------------------------
	// Pointer, lock and flag update
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			wptr_o <= 8'h00;
			swptr_q <= 8'h00;
			rptr_q <= 8'h00;
			cptr_q <= 8'h00;
			lock_q <= 1'b0;
			comp_q <= 1'b0;
			bmt_q <= 1'b0;
			abt_q <= 1'b0;
			ovr_q <= 1'b0;
		end else begin
			if (frame_start_i) begin
				swptr_q <= wptr_o;
			end
			if (frame_flush_i) begin
				wptr_o <= swptr_q;
			end else if (wr_i && !lock_q) begin
				wptr_o <= wptr_o + 8'h01;
			end
			// Set wins over clear
			if (wr_i && !lock_q && (wptr_o + 8'h01 == rptr_q)) begin
				lock_q <= 1'b1;
			end else if (clr_lock_i) begin
				lock_q <= 1'b0;
			end
			if (frame_ok_i) begin
				cptr_q <= wptr_o;
			end
			if (rd_ack_o) begin
				rptr_q <= rptr_q + 8'h01;
			end
			comp_q <= frame_ok_i | (comp_q & !clr_stat_i);
			abt_q <= frame_flush_i | (abt_q & !clr_stat_i);
			ovr_q <= (wr_i & lock_q) | (ovr_q & !clr_stat_i);
			bmt_q <= (rd_ack_o && (rptr_q + 8'h01 == cptr_q)) | (bmt_q & !clr_stat_i);
		end
	end

endmodule

// ===== verification/rfq_top_assertions.sv
/*
 Port-level checker for the flush/inhibit and dual receive queue top.
 Assumes it is bound to rfq_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module rfq_top_chk (
	input wire CORE_CLK_I,
	input wire SYS_RST_I,
	input wire [3:0] AVS_ADDRESS_I,
	input wire AVS_READ_I,
	input wire AVS_WRITE_I,
	input wire [31:0] AVS_READDATA_O,
	input wire AVS_WAITREQUEST_O,
	input wire FLUSH_INHIBIT_PIN_I,
	input wire RX_FRAME_END_I,
	input wire [2:0] HOST_SERVICE_REQUEST_I,
	input wire HOST_READ_REQ_I,
	input wire HOST_READ_ACK_O,
	input wire QUEUE_ONE_DATA_PRESENT_O,
	input wire QUEUE_TWO_DATA_PRESENT_O,
	input wire TX_PERMIT_O,
	input wire TOKEN_RELEASE_O
);
// ----------------------------------------
// Bus, register, queue and inhibit checks
// ----------------------------------------
default clocking cb @(posedge CORE_CLK_I); endclocking
default disable iff (SYS_RST_I);
// Taken request answers on the next cycle
chk_bus_answer: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
	else $error("bus request not answered in one cycle");
// Answer stands for one cycle only
chk_bus_release: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
	else $error("waitrequest low for more than one cycle");
// No answer without a request
chk_bus_idle: assert property (!(AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
	else $error("waitrequest dropped without request");
chk_old_status: assert property (!AVS_WAITREQUEST_O && AVS_READ_I && AVS_ADDRESS_I == 4'h5 |-> AVS_READDATA_O[10:9] == 2'h0)
	else $error("old frame status bits read nonzero");
chk_old_mode: assert property (!AVS_WAITREQUEST_O && AVS_READ_I && AVS_ADDRESS_I == 4'h0 |-> AVS_READDATA_O[15] == 1'b0)
	else $error("old mode bit read nonzero");
chk_ack_present: assert property (HOST_READ_ACK_O |-> $past(HOST_READ_REQ_I) &&
	($past(HOST_SERVICE_REQUEST_I) == 3'h1 ? $past(QUEUE_TWO_DATA_PRESENT_O) : $past(QUEUE_ONE_DATA_PRESENT_O)))
	else $error("read acknowledged without data present");
chk_q1_delay: assert property ($rose(QUEUE_ONE_DATA_PRESENT_O) |-> $past(RX_FRAME_END_I, 2))
	else $error("queue one present not two cycles after frame end");
chk_q2_delay: assert property ($rose(QUEUE_TWO_DATA_PRESENT_O) |-> $past(RX_FRAME_END_I, 2))
	else $error("queue two present not two cycles after frame end");
chk_inhibit_cause: assert property (!TX_PERMIT_O |-> $past(FLUSH_INHIBIT_PIN_I, 1) || $past(FLUSH_INHIBIT_PIN_I, 2)
	|| $past(FLUSH_INHIBIT_PIN_I, 3) || $past(FLUSH_INHIBIT_PIN_I, 4))
	else $error("transmit held without pin");
chk_token_pulse: assert property (TOKEN_RELEASE_O |-> !TX_PERMIT_O ##1 !TOKEN_RELEASE_O)
	else $error("token release not a pulse under inhibit");
// Main scenarios reached
cov_ack: cover property (HOST_READ_ACK_O);
cov_token: cover property (TOKEN_RELEASE_O);
cov_q2: cover property ($rose(QUEUE_TWO_DATA_PRESENT_O));
endmodule
bind rfq_top rfq_top_chk rfq_top_chk_inst (.CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I),
	.AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
	.AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
	.FLUSH_INHIBIT_PIN_I(FLUSH_INHIBIT_PIN_I), .RX_FRAME_END_I(RX_FRAME_END_I),
	.HOST_SERVICE_REQUEST_I(HOST_SERVICE_REQUEST_I), .HOST_READ_REQ_I(HOST_READ_REQ_I),
	.HOST_READ_ACK_O(HOST_READ_ACK_O), .QUEUE_ONE_DATA_PRESENT_O(QUEUE_ONE_DATA_PRESENT_O),
	.QUEUE_TWO_DATA_PRESENT_O(QUEUE_TWO_DATA_PRESENT_O), .TX_PERMIT_O(TX_PERMIT_O),
	.TOKEN_RELEASE_O(TOKEN_RELEASE_O));

// ===== verification/rfq_host_model.sv
/*
 Host read logic model: requests words from one receive queue.
 Assumes start is a one-cycle pulse on the core clock while done is high.
*/
`timescale 1ns/1ps
module rfq_host_model (
	input wire clk_i,
	input wire start_i,
	input wire [2:0] code_i,
	input wire [7:0] words_i,
	input wire [3:0] gap_i,
	input wire ack_i,
	output reg req_o,
	output reg [2:0] hsr_o,
	output reg [7:0] got_o,
	output reg done_o
);
integer n;
initial begin
	req_o = 1'b0;
	hsr_o = 3'h7;
	got_o = 8'h00;
	done_o = 1'b1;
end
// Acks counted mid-cycle, away from the launching edge
always @(negedge clk_i) begin
	if (ack_i === 1'b1) begin
		got_o <= got_o + 8'h01;
	end
end
// Gap zero keeps the request up back to back, else one word per burst
initial forever begin
	@(posedge clk_i);
	if (start_i === 1'b1 && done_o) begin
		done_o <= 1'b0;
		for (n = 0; n < words_i; n = n + 1) begin
			hsr_o <= code_i;
			req_o <= 1'b1;
			@(posedge clk_i);
			if (gap_i != 4'h0) begin
				req_o <= 1'b0;
				hsr_o <= ~code_i;
				repeat (gap_i) @(posedge clk_i);
			end
		end
		req_o <= 1'b0;
		hsr_o <= ~code_i;
		repeat (3) @(posedge clk_i);
		done_o <= 1'b1;
	end
end
endmodule

// ===== verification/test_rfq_top.sv
/*
 Self-checking bench for rfq_top with a host read model.
 Assumes the checker and host model are compiled before it.
*/
`timescale 1ns/1ps
module test_rfq_top;
reg clk, rst, rd, wr, pin, fs, bv, thr, fe, cp, busy, go, dual;
reg [3:0] adr, be, gap;
reg [31:0] wd, d, p0;
reg [2:0] cls, code;
reg [7:0] nw;
wire [31:0] rdat;
wire wq, ack, q1, q2, perm, tok, req, hdone;
wire [2:0] hsr;
wire [7:0] got;
integer err_count, tests_run, i, j, r;
rfq_top rfq_top_inst (.CORE_CLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
	.AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wq),
	.FLUSH_INHIBIT_PIN_I(pin), .RX_FRAME_START_I(fs), .RX_BYTE_VALID_I(bv), .RX_THRESHOLD_CROSSED_I(thr),
	.RX_FRAME_END_I(fe), .RX_FRAME_CLASS_I(cls), .RX_COPY_I(cp), .TX_BUSY_I(busy),
	.HOST_SERVICE_REQUEST_I(hsr), .HOST_READ_REQ_I(req), .HOST_READ_ACK_O(ack),
	.QUEUE_ONE_DATA_PRESENT_O(q1), .QUEUE_TWO_DATA_PRESENT_O(q2), .TX_PERMIT_O(perm), .TOKEN_RELEASE_O(tok));
rfq_host_model rfq_host_model_inst (.clk_i(clk), .start_i(go), .code_i(code), .words_i(nw), .gap_i(gap),
	.ack_i(ack), .req_o(req), .hsr_o(hsr), .got_o(got), .done_o(hdone));
// ----------------------------------------
// Expectation functions
// ----------------------------------------
function match(input [3:0] s, input [2:0] c, input pr);
	case (s)
		4'h1: match = (c <= 3'h1);
		4'h2: match = (c == 3'h2);
		4'h3: match = (c != 3'h2) && (pr || (c != 3'h3 && c != 3'h5));
		4'h4: match = (c == 3'h4);
		4'h5: match = (c == 3'h3);
		4'h6: match = (c == 3'h0);
		4'h7: match = (c == 3'h1);
		4'h8: match = (c == 3'h5);
		4'h9: match = (c == 3'h1 || c == 3'h2);
		default: match = 1'b0;
	endcase
endfunction
// Bit 0 queue one, bit 1 queue two; queue one checked first
function [1:0] steer(input [3:0] s1, input [3:0] s2, input pr, input [2:0] c, input k, input du);
	if (!k) steer = 2'h0;
	else if (!du || s1 == s2) steer = 2'h1;
	else if (s1 == 4'h0) steer = {match(s2, c, pr), 1'b0};
	else if (match(s1, c, pr)) steer = 2'h1;
	else if (s2 == 4'h0 || match(s2, c, pr)) steer = 2'h2;
	else steer = 2'h0;
endfunction
// ----------------------------------------
// Tasks
// ----------------------------------------
task chk(input [31:0] g, input [31:0] e);
	begin
		tests_run = tests_run + 1;
		if (g !== e) begin
			err_count = err_count + 1;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	end
endtask
// Avalon cycle: held until waitrequest seen low
task bus(input w, input [3:0] a, input [15:0] v);
	integer n;
	begin
		n = 0;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= {16'h0000, v};
		// Waitrequest and read data taken at the rising edge
		do begin
			@(posedge clk);
			n = n + 1;
		end while (wq !== 1'b0 && n < 40);
		d = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 40) chk(32'h0, 32'h1);
	end
endtask
task send(input [2:0] c, input k, input [8:0] n, input late);
	integer m;
	begin
		@(posedge clk);
		fs <= 1'b1;
		cls <= c;
		cp <= k;
		@(posedge clk);
		fs <= 1'b0;
		for (m = 0; m < n; m = m + 1) begin
			bv <= 1'b1;
			thr <= (m == 1);
			if (late && m == 3) pin <= 1'b1;
			@(posedge clk);
		end
		bv <= 1'b0;
		thr <= 1'b0;
		fe <= 1'b1;
		@(posedge clk);
		fe <= 1'b0;
		repeat (4) @(posedge clk);
	end
endtask
// Frame with pointer advance per queue compared
task fd(input [2:0] c, input k, input [8:0] n, input late, input [7:0] e1, input [7:0] e2);
	reg [7:0] t;
	begin
		bus(0, 4'h7, 16'h0000);
		p0 = d;
		send(c, k, n, late);
		bus(0, 4'h7, 16'h0000);
		t = d[7:0] - p0[7:0];
		chk({24'h0, t}, {24'h0, e1});
		t = d[15:8] - p0[15:8];
		chk({24'h0, t}, {24'h0, e2});
	end
endtask
task try(input [3:0] s1, input [3:0] s2, input pr, input [2:0] c, input k);
	reg [1:0] e;
	begin
		e = steer(s1, s2, pr, c, k, dual);
		bus(1, 4'h2, {8'h00, s2, s1});
		bus(1, 4'h0, {15'h0000, pr});
		fd(c, k, 3, 0, e[0] ? 8'h03 : 8'h00, e[1] ? 8'h03 : 8'h00);
	end
endtask
task hread(input [2:0] c, input [7:0] n, input [3:0] g, input [7:0] e);
	reg [7:0] g0;
	integer m;
	begin
		g0 = got;
		m = 0;
		@(posedge clk);
		code <= c;
		nw <= n;
		gap <= g;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		do begin
			@(negedge clk);
			m = m + 1;
		end while (hdone !== 1'b1 && m < 2000);
		g0 = got - g0;
		chk({24'h0, g0}, {24'h0, e});
	end
endtask
task complete_run;
	begin
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
endtask
// ----------------------------------------
// Clock, watchdog and main sequence
// ----------------------------------------
initial begin
	clk = 1'b0;
	forever #5 clk = ~clk;
end
initial begin
	repeat (60000) @(posedge clk);
	err_count = err_count + 1;
	complete_run;
end
initial begin
	{rd, wr, pin, fs, bv, thr, fe, cp, busy, go, dual} = 11'h000;
	{adr, gap, cls, code, nw, wd} = 0;
	be = 4'h3;
	err_count = 0;
	tests_run = 0;
	rst = 1'b1;
	r = $urandom(18031);
	repeat (12) @(posedge clk);
	rst <= 1'b0;
	for (i = 0; i < 4; i = i + 1) begin
		bus(0, i[3:0], 16'h0000);
		chk(d, 32'h0);
	end
	bus(1, 4'h0, 16'hFFFF);
	bus(0, 4'h0, 16'h0000);
	chk(d, 32'h7FFF);
	bus(1, 4'hA, 16'h1234);
	bus(0, 4'hA, 16'h0000);
	chk(d, 32'h0);
	$display("test registers done");
	try(4'h2, 4'h5, 1'b0, 3'h2, 1'b1);
	chk(q1, 1);
	chk(q2, 0);
	hread(3'h1, 8'h02, 4'h1, 8'h00);
	hread(3'h0, 8'h03, 4'h0, 8'h03);
	chk(q1, 0);
	try(4'h0, 4'h0, 1'b0, 3'h2, 1'b0);
	$display("test single queue done");
	for (i = 0; i < 4; i = i + 1) begin
		bus(1, 4'h3, i[15:0]);
		pin <= 1'b1;
		repeat (6) @(posedge clk);
		chk(perm, i != 2);
		fd(3'h2, 1'b1, 2, 0, i == 1 ? 8'h00 : 8'h02, 8'h00);
		pin <= 1'b0;
		repeat (6) @(posedge clk);
	end
	bus(1, 4'h3, 16'h0001);
	fd(3'h2, 1'b1, 6, 1, 8'h06, 8'h00);
	pin <= 1'b0;
	bus(1, 4'h3, 16'h0002);
	busy <= 1'b1;
	pin <= 1'b1;
	repeat (8) @(posedge clk);
	chk(perm, 0);
	busy <= 1'b0;
	j = 0;
	while (tok !== 1'b1 && j < 10) begin
		@(negedge clk);
		j = j + 1;
	end
	chk(j < 10, 1);
	@(posedge clk);
	pin <= 1'b0;
	repeat (8) @(posedge clk);
	chk(perm, 1);
	bus(1, 4'h3, 16'h0000);
	$display("test pin roles done");
	dual = 1'b1;
	bus(1, 4'h1, 16'h0800);
	try(4'h2, 4'h2, 1'b0, 3'h1, 1'b1);
	try(4'h0, 4'h0, 1'b0, 3'h1, 1'b1);
	try(4'h0, 4'h2, 1'b0, 3'h1, 1'b1);
	try(4'h1, 4'h6, 1'b0, 3'h0, 1'b1);
	try(4'h3, 4'h2, 1'b1, 3'h5, 1'b1);
	try(4'h3, 4'h2, 1'b0, 3'h3, 1'b1);
	try(4'h2, 4'h0, 1'b0, 3'h1, 1'b1);
	chk(q2, 1);
	bus(0, 4'h6, 16'h0000);
	chk(d & 32'h8000, 32'h8000);
	for (i = 1; i < 10; i = i + 1) try(i[3:0], 4'h0, $urandom % 2, $urandom % 6, 1'b1);
	repeat (20) try($urandom % 10, $urandom % 10, $urandom % 2, $urandom % 6, ($urandom % 4) != 0);
	$display("test dual queue done");
	dual = 1'b0;
	bus(1, 4'h1, 16'h0000);
	bus(0, 4'h5, 16'h0000);
	send(3'h2, 1'b1, 300, 0);
	bus(0, 4'h5, 16'h0000);
	chk(d & 32'h1E00, 32'h1800);
	bus(1, 4'h4, 16'h0040);
	bus(0, 4'h5, 16'h0000);
	chk(d & 32'h1800, 32'h1000);
	bus(1, 4'h4, 16'h0020);
	bus(0, 4'h5, 16'h0000);
	chk(d & 32'h1000, 32'h0);
	$display("test queue lock done");
	complete_run;
end
endmodule
